// ### src/graphic_lcd_host_interface.sv
// host port, display memory and scan of a two-half dot-matrix controller
//
// Functional notes
// - deselected chip ignores every transfer
// - init pin and segment order ignore selects
// - written byte held, then stored internally
// - select and direction lines pick access type
// - memory read needs dummy read first
// - status read answers immediately
// - init turns display off, start line zero
// - during init only status read accepted; data reads return held byte, no refill
// - busy flag shown on bit seven
// - flip-flop set blanks segments to non-selective
// - on/off flip-flop shown on bit five
// - segments blank while init pin low
// - page register changes only by instruction
// - column counter loads, advances after access
// - memory one lights dot, zero leaves off
// - start line takes six low bits
// - frame signal presets scan line counter
// - on/off instruction sets display, keeps memory
// - prefix 01 loads column counter
// - prefix 10111 loads page register
// - prefix 11 loads display start line
//
// pin path: every host pin passes two flops, so a strobe edge takes effect
// three clocks after it reaches the pin; the strobe must stay high and low
// for at least one clock each or the edge detector misses the change
//
// reads: the answer is launched on the strobe rise and held until the next
// read rise; the output enable drops on the rise and rises again on the fall;
// a data read returns the output register and refills it on the fall, so the
// first read after a column load is a dummy
//
// writes: taken on the strobe fall into one holding word, moved into the
// queue when it has room, and applied one word per internal operation slot;
// instructions and data share the queue so their order is kept
//
// instructions: on/off, column load, page load and start line load are told
// apart by their top bits; any other code is taken and ignored
//
// busy: high while the holding word or the queue is occupied; a write that
// arrives while the holding word is still full and the queue has no room is dropped, which is the price
// of a single holding word instead of back pressure on the pins
//
// status byte: bit 7 busy, bit 5 display off, bit 4 init in progress, the
// rest read zero
//
// init pin: forces display off and start line zero on both halves every
// clock it is low, blanks the segments, drops writes and answers data reads with the held byte without refill or column step;
// words already queued still drain, but init wins over a queued on command
//
// scan: one line step per line period, preset from the start line while the
// frame input is high; segments lag the line counter by one clock
//
// limitation: reads do not wait for queued writes, so a host that reads while
// busy may see memory from before them; a read that finishes in the same
// slot as a queued word for its half holds that word back one slot
`timescale 1ns/10ps
module graphic_lcd_host_interface (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable_strobe,
  input wire logic register_select_line,
  input wire logic read_not_write,
  input wire logic [lcd_host_pkg::BYTE_W-1:0] db_in,
  output logic [lcd_host_pkg::BYTE_W-1:0] db_out,
  output logic db_oe_n,
  input wire logic left_half_select,
  input wire logic right_half_select,
  input wire logic active_low_init_pin,
  input wire logic segment_order_reverse,
  input wire logic frame_sync,
  output logic [lcd_host_pkg::COLS-1:0] seg_left,
  output logic [lcd_host_pkg::COLS-1:0] seg_right
);
  import lcd_host_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic e_prev;
    logic [HALVES-1:0][COL_W-1:0] col;
    logic [HALVES-1:0][PAGE_W-1:0] page;
    logic [HALVES-1:0][LINE_W-1:0] start_line;
    logic [HALVES-1:0][LINE_W-1:0] z_line;
    logic [HALVES-1:0] display_off;
    logic [HALVES-1:0][BYTE_W-1:0] out_reg;
    logic [MEM_DEPTH-1:0][BYTE_W-1:0] mem;
    logic [CMD_W-1:0] pend_word;
    logic pend_valid;
    logic [OP_CNT_W-1:0] op_cnt;
    logic [LINE_CNT_W-1:0] line_cnt;
    logic [BYTE_W-1:0] db_out;
    logic db_oe_n;
    logic [HALVES-1:0][COLS-1:0] seg;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  byte_stream_if #(.WIDTH(CMD_W)) cmd_in ();
  byte_stream_if #(.WIDTH(CMD_W)) cmd_out ();

  // synchronised views, all taken from the second flop
  logic [PIN_W-1:0] pin_bus;
  logic e_s;
  logic rs_s;
  logic rw_s;
  logic init_low;
  logic adc_s;
  logic frm_s;
  logic [BYTE_W-1:0] db_s;
  logic [HALVES-1:0] sel;

  // access control, dividers and status
  logic rd_half;
  logic e_rise;
  logic e_fall;
  logic op_tick;
  logic line_tick;
  logic busy;
  logic [BYTE_W-1:0] status_byte;

  // queue head, read collision and memory indexing
  logic rd_done;
  logic rd_clash;
  logic [BYTE_W-1:0] op_byte;
  logic [COL_W-1:0] scan_col;
  logic [MEM_AW-1:0] idx;

  assign pin_bus = {enable_strobe, register_select_line, read_not_write, left_half_select,
                    right_half_select, active_low_init_pin, segment_order_reverse,
                    frame_sync, db_in};
  assign e_s = st.sync2[PIN_E];
  assign rs_s = st.sync2[PIN_RS];
  assign rw_s = st.sync2[PIN_RW];
  assign init_low = ~st.sync2[PIN_INIT_N];
  assign adc_s = st.sync2[PIN_ADC];
  assign frm_s = st.sync2[PIN_FRM];
  assign db_s = st.sync2[PIN_DB_LSB +: BYTE_W];
  assign sel = {st.sync2[PIN_CS_R], st.sync2[PIN_CS_L]};
  // both halves selected reads from the left one; the host should pick one
  assign rd_half = ~st.sync2[PIN_CS_L];
  assign e_rise = e_s & ~st.e_prev;
  assign e_fall = ~e_s & st.e_prev;

  // dividers: internal operation rate and scan line rate
  assign op_tick = (st.op_cnt == '0);
  assign line_tick = (st.line_cnt == '0);

  // a data read completes on the strobe fall and steps its half's column counter
  assign rd_done = e_fall & (sel != '0) & ~init_low & rw_s & rs_s;
  // both paths move the same column counter in one clock, so one step would be
  // lost; the queue head waits one slot when it names the half being read
  assign rd_clash = rd_done & cmd_out.data[CMD_HALF_LSB + rd_half];

  // queue hand-off; the drain side only moves at the internal operation rate
  assign cmd_in.valid = st.pend_valid;
  assign cmd_in.data = st.pend_word;
  assign cmd_out.ready = op_tick & ~rd_clash;
  assign op_byte = cmd_out.data[BYTE_W-1:0];

  // busy while any accepted write is still waiting or queued
  assign busy = st.pend_valid | cmd_out.valid;

  always_comb begin
    status_byte = '0;
    status_byte[STAT_BUSY_BIT] = busy;
    status_byte[STAT_OFF_BIT] = st.display_off[rd_half];
    status_byte[STAT_RESET_BIT] = init_low;
  end

  cmd_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fill(cmd_in),
    .drain(cmd_out)
  );

  // next-state logic for the whole port
  always_comb begin
    next_st = st;
    scan_col = '0;
    idx = '0;
    // pins shift through the two synchroniser stages
    next_st.sync1 = pin_bus;
    next_st.sync2 = st.sync1;
    next_st.e_prev = e_s;

    // divider counters reload when they reach zero
    next_st.op_cnt = op_tick ? OP_CNT_W'(OP_CYCLES - 1) : st.op_cnt - 1'b1;
    next_st.line_cnt = line_tick ? LINE_CNT_W'(LINE_CYCLES - 1) : st.line_cnt - 1'b1;

    // bus strobe rising: drive the answer of a selected read
    if (e_rise && (sel != '0) && rw_s) begin
      next_st.db_oe_n = 1'b0;
      if (rs_s) begin
        next_st.db_out = st.out_reg[rd_half];
      end else begin
        next_st.db_out = status_byte;
      end
    end

    // bus strobe falling: end the read drive and complete the access
    if (e_fall) begin
      next_st.db_oe_n = 1'b1;
      if ((sel != '0) && !init_low) begin
        if (rw_s && rs_s) begin
          // the held byte was just returned; fetch the next one for the following read
          idx = {rd_half, st.page[rd_half], st.col[rd_half]};
          next_st.out_reg[rd_half] = st.mem[idx];
          next_st.col[rd_half] = st.col[rd_half] + 1'b1;
        end else if (!rw_s && !st.pend_valid) begin
          // a write arriving while one is still pending is taken below only if that one enters the queue now, else dropped
          next_st.pend_word = {sel, rs_s, db_s};
          next_st.pend_valid = 1'b1;
        end
      end
    end

    // the pending word enters the queue once it has room
    if (st.pend_valid && cmd_in.ready) begin
      next_st.pend_valid = 1'b0;
      if (e_fall && (sel != '0) && !init_low && !rw_s) begin
        next_st.pend_word = {sel, rs_s, db_s};
        next_st.pend_valid = 1'b1;
      end
    end

    // internal operation: apply one queued word to each half it names
    if (cmd_out.valid && cmd_out.ready) begin
      for (int h = 0; h < HALVES; h++) begin
        if (cmd_out.data[CMD_HALF_LSB + h]) begin
          if (cmd_out.data[CMD_RS_BIT]) begin
            idx = {1'(h), st.page[h], st.col[h]};
            next_st.mem[idx] = op_byte;
            next_st.col[h] = st.col[h] + 1'b1;
          end else if ((op_byte & ONOFF_MASK) == ONOFF_CODE) begin
            next_st.display_off[h] = ~op_byte[0];
          end else if ((op_byte & COL_MASK) == COL_CODE) begin
            next_st.col[h] = op_byte[COL_W-1:0];
          end else if ((op_byte & PAGE_MASK) == PAGE_CODE) begin
            next_st.page[h] = op_byte[PAGE_W-1:0];
          end else if ((op_byte & LINE_MASK) == LINE_CODE) begin
            next_st.start_line[h] = op_byte[LINE_W-1:0];
          end
        end
      end
    end

    // init pin acts regardless of the selects and overrides queued on/off and start line instructions
    if (init_low) begin
      next_st.display_off = {HALVES{DISPLAY_OFF_RST}};
      next_st.start_line = {HALVES{START_LINE_RST}};
    end

    // scan: frame preset, otherwise step one line per line period
    for (int h = 0; h < HALVES; h++) begin
      if (frm_s) begin
        next_st.z_line[h] = st.start_line[h];
      end else if (line_tick) begin
        next_st.z_line[h] = st.z_line[h] + 1'b1;
      end
    end

    // segment levels of the current scan line, column order set by the order pin
    for (int h = 0; h < HALVES; h++) begin
      for (int c = 0; c < COLS; c++) begin
        scan_col = COL_W'(c) ^ {COL_W{adc_s}};
        idx = {1'(h), st.z_line[h][LINE_W-1:PAGE_W], scan_col};
        // one lights the dot; off flip-flop or init forces non-selective level
        next_st.seg[h][c] = st.mem[idx][st.z_line[h][PAGE_W-1:0]]
                            & ~st.display_off[h]
                            & ~init_low;
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      // flip-flops with package reset values; display_off and db_oe_n reset to one, start line to zero
      st.display_off <= {HALVES{DISPLAY_OFF_RST}};
      st.start_line <= {HALVES{START_LINE_RST}};
      st.db_oe_n <= OE_N_RST;
    end else begin
      st <= next_st;
    end
  end

  // every output comes straight from the state register
  assign db_out = st.db_out;
  assign db_oe_n = st.db_oe_n;
  assign seg_left = st.seg[0];
  assign seg_right = st.seg[1];
endmodule : graphic_lcd_host_interface

// ### include/lcd_host_pkg.sv
// constants and field layouts of the graphic display host port
package lcd_host_pkg;
  // clock and derived timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_TIME_NS = 40;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_TIME_NS = 1000;
  localparam int LINE_CYCLES = LINE_TIME_NS / CLK_PERIOD_NS;
  localparam int OP_CNT_W = 4;
  localparam int LINE_CNT_W = 8;

  // display memory geometry
  localparam int HALVES = 2;
  localparam int COLS = 64;
  localparam int COL_W = 6;
  localparam int PAGE_W = 3;
  localparam int LINE_W = 6;
  localparam int MEM_AW = 1 + PAGE_W + COL_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int BYTE_W = 8;

  // queued write word: {half mask, register select, byte}
  localparam int CMD_W = HALVES + 1 + BYTE_W;
  localparam int CMD_RS_BIT = 8;
  localparam int CMD_HALF_LSB = 9;
  localparam int FIFO_DEPTH = 8;

  // synchronised pin bundle layout
  localparam int PIN_W = 16;
  localparam int PIN_DB_LSB = 0;
  localparam int PIN_FRM = 8;
  localparam int PIN_ADC = 9;
  localparam int PIN_INIT_N = 10;
  localparam int PIN_CS_R = 11;
  localparam int PIN_CS_L = 12;
  localparam int PIN_RW = 13;
  localparam int PIN_RS = 14;
  localparam int PIN_E = 15;

  // instruction patterns (mask, code)
  localparam logic [7:0] ONOFF_MASK = 8'hfe;
  localparam logic [7:0] ONOFF_CODE = 8'h3e;
  localparam logic [7:0] COL_MASK = 8'hc0;
  localparam logic [7:0] COL_CODE = 8'h40;
  localparam logic [7:0] PAGE_MASK = 8'hf8;
  localparam logic [7:0] PAGE_CODE = 8'hb8;
  localparam logic [7:0] LINE_MASK = 8'hc0;
  localparam logic [7:0] LINE_CODE = 8'hc0;

  // status byte bit positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_OFF_BIT = 5;
  localparam int STAT_RESET_BIT = 4;

  // reset values
  localparam logic DISPLAY_OFF_RST = 1'b1;
  localparam logic [LINE_W-1:0] START_LINE_RST = 6'h00;
  localparam logic OE_N_RST = 1'b1;
endpackage : lcd_host_pkg

// ### include/byte_stream_if.sv
// valid/ready word stream between the port logic and its write queue
`timescale 1ns/10ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport sender (output valid, output data, input ready);
  modport receiver (input valid, input data, output ready);
endinterface : byte_stream_if

// ### src/cmd_fifo.sv
// parameterised flip-flop queue with valid/ready on both sides
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  byte_stream_if.receiver fill,
  byte_stream_if.sender drain
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign fill.ready = (st.count != (AW+1)'(DEPTH));
  assign drain.valid = (st.count != '0);
  assign drain.data = st.mem[st.rd_ptr];

  // pointer and count update
  always_comb begin
    next_st = st;
    push = fill.valid & fill.ready;
    pop = drain.valid & drain.ready;
    if (push) begin
      next_st.mem[st.wr_ptr] = fill.data;
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : cmd_fifo

// ### testbench/graphic_lcd_host_interface_asserts.sv
// pin-level checks on the display host port
`timescale 1ns/10ps
module lcd_port_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable_strobe,
  input wire logic register_select_line,
  input wire logic read_not_write,
  input wire logic [7:0] db_out,
  input wire logic db_oe_n,
  input wire logic left_half_select,
  input wire logic right_half_select,
  input wire logic active_low_init_pin,
  input wire logic frame_sync,
  input wire logic [63:0] seg_left,
  input wire logic [63:0] seg_right
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // six clocks covers the two-flop sync plus edge detect
  quiet_when_off_a: assert property ((!left_half_select && !right_half_select) [*6] |-> db_oe_n)
    else $error("bus driven while deselected");
  status_answer_a: assert property ($rose(enable_strobe) && read_not_write && left_half_select
    && !register_select_line |-> ##[3:4] !db_oe_n) else $error("status read not answered");
  write_no_drive_a: assert property ($rose(enable_strobe) && !read_not_write |-> db_oe_n [*6])
    else $error("bus driven on write");
  bus_release_a: assert property ($fell(enable_strobe) |-> ##[3:4] db_oe_n)
    else $error("bus not released");
  held_byte_a: assert property (!db_oe_n && !$past(db_oe_n) |-> $stable(db_out))
    else $error("read byte changed while driven");
  status_zeros_a: assert property ($fell(db_oe_n) && !register_select_line
    |-> db_out[6] == 1'b0 && db_out[3:0] == 4'h0) else $error("status fixed bits wrong");
  init_status_a: assert property (!active_low_init_pin [*6] ##0 ($fell(db_oe_n)
    && !register_select_line) |-> db_out[5:4] == 2'b11) else $error("init not in status");
  init_blank_a: assert property (!active_low_init_pin [*6] |-> seg_left == '0 && seg_right == '0)
    else $error("segments lit during init");
  reset_blank_a: assert property (disable iff (1'b0) !rst_n |=> db_oe_n && seg_left == '0)
    else $error("reset left outputs active");
  cover property ($fell(db_oe_n) && register_select_line);
  cover property ($rose(frame_sync) ##1 frame_sync);
  cover property (!active_low_init_pin ##1 $fell(db_oe_n));
endmodule : lcd_port_checker
bind graphic_lcd_host_interface lcd_port_checker checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .enable_strobe(enable_strobe), .register_select_line(register_select_line),
  .read_not_write(read_not_write), .db_out(db_out), .db_oe_n(db_oe_n),
  .left_half_select(left_half_select), .right_half_select(right_half_select),
  .active_low_init_pin(active_low_init_pin), .frame_sync(frame_sync),
  .seg_left(seg_left), .seg_right(seg_right));

// ### testbench/lcd_host_model.sv
// processor model driving the parallel display bus pins
`timescale 1ns/10ps
module lcd_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] db_out,
  output logic e_pin,
  output logic rs_pin,
  output logic rnw_pin,
  output logic [7:0] db_pin,
  output logic [1:0] sel_pin
);
  initial begin
    e_pin = 1'b0;
    rs_pin = 1'b0;
    rnw_pin = 1'b1;
    db_pin = 8'h00;
    sel_pin = 2'b00;
  end
  // strobe high and low six clocks each, well past the pin sync delay
  task automatic access(input logic rs, input logic rnw, input logic [1:0] sel,
    input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge sys_clk);
    rs_pin <= rs;
    rnw_pin <= rnw;
    sel_pin <= sel;
    db_pin <= rnw ? ~db_pin : wdata;
    repeat (2) @(posedge sys_clk);
    e_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rdata = db_out;
    e_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    sel_pin <= 2'b00;
    db_pin <= ~db_pin; // released bus must not keep its last value
  endtask : access
endmodule : lcd_host_model

// ### testbench/graphic_lcd_host_interface_bench.sv
// self-checking bench for the display host port
`timescale 1ns/10ps
module graphic_lcd_host_interface_bench;
  import lcd_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic init_n = 1'b1;
  logic rev = 1'b0;
  logic frame = 1'b0;
  logic e, rs, rnw, db_oe_n;
  logic [1:0] sel;
  logic [7:0] db, db_out;
  logic [63:0] seg_left, seg_right;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  lcd_host_model host (.sys_clk(sys_clk), .db_out(db_out), .e_pin(e), .rs_pin(rs),
    .rnw_pin(rnw), .db_pin(db), .sel_pin(sel));
  graphic_lcd_host_interface dut (.sys_clk(sys_clk), .rst_n(rst_n), .enable_strobe(e),
    .register_select_line(rs), .read_not_write(rnw), .db_in(db), .db_out(db_out),
    .db_oe_n(db_oe_n), .left_half_select(sel[0]), .right_half_select(sel[1]),
    .active_low_init_pin(init_n), .segment_order_reverse(rev), .frame_sync(frame),
    .seg_left(seg_left), .seg_right(seg_right));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic stat(output logic [7:0] q);
    host.access(1'b0, 1'b1, 2'b01, 8'h00, q);
  endtask : stat
  task automatic rd(output logic [7:0] q);
    host.access(1'b1, 1'b1, 2'b01, 8'h00, q);
  endtask : rd
  // every write waits out busy, so the queue never overflows
  task automatic wr(input logic r, input logic [7:0] d, input logic [1:0] s = 2'b01);
    logic [7:0] q;
    int n;
    host.access(r, 1'b0, s, d, q);
    n = 0;
    q = 8'h80;
    while (q[7] !== 1'b0 && n < 20) begin
      stat(q);
      n++;
    end
    check("busy", q[7], 1'b0);
  endtask : wr
  task automatic t_write_read();
    logic [7:0] q;
    stat(q);
    check("reset status", q, 8'h20);
    wr(1'b0, 8'h3f);
    stat(q);
    check("on status", q, 8'h00);
    wr(1'b0, PAGE_CODE | 8'h03);
    wr(1'b0, COL_CODE | 8'h3e);
    wr(1'b1, 8'ha5);
    wr(1'b1, 8'h5a);
    wr(1'b1, 8'h11);
    wr(1'b0, COL_CODE | 8'h3e);
    rd(q);
    rd(q);
    check("rd col62", q, 8'ha5);
    rd(q);
    check("rd col63", q, 8'h5a);
    rd(q);
    check("rd col0", q, 8'h11);
  endtask : t_write_read
  // deselected data and column loads must not land: col62 holds 3c, col63 stays 00
  task automatic t_page_select();
    logic [7:0] q;
    wr(1'b0, PAGE_CODE | 8'h04);
    wr(1'b0, COL_CODE | 8'h3e);
    wr(1'b1, 8'h3c);
    wr(1'b1, 8'hff, 2'b00);
    wr(1'b0, COL_CODE | 8'h3e, 2'b00);
    rd(q);
    rd(q);
    check("page4 col63", q, 8'h00);
  endtask : t_page_select
  task automatic t_init();
    logic [7:0] q;
    init_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    stat(q);
    check("init status", q, 8'h30);
    wr(1'b0, 8'h3f);
    stat(q);
    check("on refused", q, 8'h30);
    // a data byte sent during init must not reach page 4 col 1
    wr(1'b1, 8'hc3);
    init_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    stat(q);
    check("after init", q, 8'h20);
    wr(1'b0, COL_CODE | 8'h01);
    rd(q);
    rd(q);
    check("init data refused", q, 8'h00);
  endtask : t_init
  // start line 24 shows bit 0 of page 3; line period is 200 clocks
  task automatic t_scroll();
    wr(1'b0, 8'h3f);
    wr(1'b0, LINE_CODE | 8'h18);
    frame <= 1'b1;
    repeat (420) @(posedge sys_clk);
    check("seg 63:62", seg_left[63:62], 2'b01);
    check("seg 0", seg_left[0], 1'b1);
    check("right", seg_right, 64'h0);
    rev <= 1'b1;
    repeat (420) @(posedge sys_clk);
    check("rev seg 1:0", seg_left[1:0], 2'b10);
    wr(1'b0, 8'h3e);
    repeat (420) @(posedge sys_clk);
    check("off seg", seg_left, 64'h0);
  endtask : t_scroll
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // roughly 2000 clocks of traffic; ten times that means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_write_read();
    t_page_select();
    t_init();
    t_scroll();
    give_verdict();
  end
endmodule : graphic_lcd_host_interface_bench
